// ### src/cms_pkg.sv
/*
  Shared types and constants for the configuration and mode sequencer.
  Assumes a single 10 MHz system clock.
*/
`default_nettype none
package cms_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned LOAD_LIMIT_MS = 100;
  localparam int unsigned LOAD_LIMIT_CYC = (LOAD_LIMIT_MS * (CLK_HZ / 1000));
  localparam int unsigned INIT_CYC_DEF = 16;
  localparam int unsigned IMAGE_BYTES_DEF = 64;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned PLL_CHAIN_BITS = 24;
  localparam logic [7:0] IDLE_BYTE = 8'h00;

  typedef enum logic [2:0] {
    CMS_SRC_MEMORY = 3'h0,
    CMS_SRC_PASSIVE_SERIAL = 3'h1,
    CMS_SRC_PASSIVE_PARALLEL_ASYNC = 3'h2,
    CMS_SRC_FAST_PARALLEL = 3'h3,
    CMS_SRC_SCAN = 3'h4
  } cms_scheme_e;

  // Gray codes along reset -> load -> init -> user
  typedef enum logic [1:0] {
    CMS_ST_RESET = 2'h0,
    CMS_ST_LOAD = 2'h1,
    CMS_ST_INIT = 2'h3,
    CMS_ST_USER = 2'h2
  } cms_state_e;

  typedef struct packed {
    logic valid;
    logic serial;
    logic [7:0] data;
  } cms_cfg_word_s;
endpackage : cms_pkg
`default_nettype wire

// ### src/cms_fifo.sv
/*
  Parameterised valid/ready FIFO for configuration bytes.
  Assumes an asynchronous active-low reset whose release is synchronised upstream.
*/
`default_nettype none
module cms_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = cms_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
  } cms_fifo_s;
  cms_fifo_s st;
  cms_fifo_s next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign in_ready = (st.count != (AW+1)'(DEPTH));
  assign out_valid = (st.count != '0);
  assign out_data = mem[st.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.wr = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
    end
    if (pop)
    begin
      next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
    end
    next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[st.wr] <= in_data;
    end
  end
endmodule : cms_fifo
`default_nettype wire

// ### src/cms_sequencer.sv
/*
  Configuration and mode sequencer: loads an image from the selected scheme,
  initialises, and runs user mode; also drives a PLL counter shift chain.
  Assumes all inputs but rst_n synchronous to clk; pad logic resolves the I/O enables.
*/
`default_nettype none
module cms_sequencer #(
  parameter int unsigned IMAGE_BYTES = cms_pkg::IMAGE_BYTES_DEF,
  parameter int unsigned INIT_CYC = cms_pkg::INIT_CYC_DEF,
  parameter int unsigned LOAD_LIMIT = cms_pkg::LOAD_LIMIT_CYC,
  parameter int unsigned IO_COUNT = 8,
  parameter int unsigned PLL_BITS = cms_pkg::PLL_CHAIN_BITS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Scheme selection and chain
  input wire cms_pkg::cms_scheme_e scheme,
  input wire logic chain_enable_in_n,
  output logic chain_enable_out_n,
  // Reconfiguration requests
  input wire logic reconfig_request_n,
  input wire logic scan_pulse_reconfig,
  // Configuration memory and serial/scan stream
  input wire logic serial_valid,
  input wire logic serial_data,
  // Parallel data: sync strobe or async host write to one location
  input wire logic par_valid,
  input wire logic par_write_n,
  input wire logic [7:0] par_data,
  output logic data_ready,
  // Status
  output logic command_mode,
  output logic user_mode,
  output logic config_done,
  output logic load_timeout,
  output logic init_reset_n,
  // User I/O pad control
  output logic [IO_COUNT-1:0] io_oe_allow,
  output logic io_weak_pullup,
  // PLL serial reprogramming
  input wire logic pll_from_pins,
  input wire logic pll_shift_logic,
  input wire logic pll_data_logic,
  input wire logic pll_shift_pin,
  input wire logic pll_data_pin,
  input wire logic pll_update,
  output logic [PLL_BITS-1:0] pll_counters
);
  localparam int unsigned BW = $clog2(IMAGE_BYTES + 1);
  localparam int unsigned LW = $clog2(LOAD_LIMIT + 1);
  localparam int unsigned IW = $clog2(INIT_CYC + 1);

  typedef struct packed {
    cms_pkg::cms_state_e state;
    logic [BW-1:0] bytes;
    logic [LW-1:0] load_cyc;
    logic [IW-1:0] init_cyc;
    logic [2:0] bit_cnt;
    logic [7:0] shreg;
    logic req_prev;
    logic wr_prev;
    logic timeout;
    logic [PLL_BITS-1:0] pll_shift;
    logic [PLL_BITS-1:0] pll_active;
  } cms_seq_s;

  cms_seq_s st;
  cms_seq_s next_st;
  logic rst_meta;
  logic rst_sync_n;
  cms_pkg::cms_cfg_word_s in_word;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic consume;
  logic restart;
  logic serial_scheme;

  function automatic logic is_serial(input cms_pkg::cms_scheme_e s);
    is_serial = (s == cms_pkg::CMS_SRC_MEMORY) || (s == cms_pkg::CMS_SRC_PASSIVE_SERIAL) ||
      (s == cms_pkg::CMS_SRC_SCAN);
  endfunction : is_serial

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // Scheme steers serial assembly or parallel capture
  assign serial_scheme = is_serial(scheme);
  // Bytes enter only while loading and enabled by the chain
  always_comb
  begin
    in_word = '0;
    in_word.serial = serial_scheme;
    if (st.state == cms_pkg::CMS_ST_LOAD && !chain_enable_in_n)
    begin
      if (serial_scheme)
      begin
        in_word.valid = serial_valid && (st.bit_cnt == 3'h7);
        in_word.data = {st.shreg[6:0], serial_data};
      end
      else if (scheme == cms_pkg::CMS_SRC_PASSIVE_PARALLEL_ASYNC)
      begin
        in_word.valid = st.wr_prev && !par_write_n;
        in_word.data = par_data;
      end
      else
      begin
        in_word.valid = par_valid;
        in_word.data = par_data;
      end
    end
  end

  assign data_ready = fifo_in_ready;

  cms_fifo #(
    .WIDTH(8),
    .DEPTH(cms_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_sync_n),
    .in_valid(in_word.valid),
    .in_ready(fifo_in_ready),
    .in_data(in_word.data),
    .out_valid(fifo_out_valid),
    .out_ready(st.state == cms_pkg::CMS_ST_LOAD),
    .out_data(fifo_out_data)
  );

  assign consume = fifo_out_valid && (st.state == cms_pkg::CMS_ST_LOAD);
  assign restart = (st.req_prev && !reconfig_request_n) || scan_pulse_reconfig;

  always_comb
  begin
    next_st = st;
    next_st.req_prev = reconfig_request_n;
    next_st.wr_prev = par_write_n;
    // PLL chain runs in any state, independent of the sequencer
    if (pll_from_pins ? pll_shift_pin : pll_shift_logic)
    begin
      next_st.pll_shift = {st.pll_shift[PLL_BITS-2:0], pll_from_pins ? pll_data_pin : pll_data_logic};
    end
    if (pll_update)
    begin
      next_st.pll_active = st.pll_shift;
    end
    case (st.state)
      cms_pkg::CMS_ST_RESET:
      begin
        next_st.bytes = '0;
        next_st.load_cyc = '0;
        next_st.bit_cnt = '0;
        next_st.state = cms_pkg::CMS_ST_LOAD;
      end
      cms_pkg::CMS_ST_LOAD:
      begin
        if (serial_scheme && serial_valid && !chain_enable_in_n && fifo_in_ready)
        begin
          next_st.shreg = {st.shreg[6:0], serial_data};
          next_st.bit_cnt = st.bit_cnt + 3'h1;
        end
        if (st.load_cyc != LW'(LOAD_LIMIT))
        begin
          next_st.load_cyc = st.load_cyc + 1'b1;
        end
        else
        begin
          next_st.timeout = 1'b1;
        end
        if (consume)
        begin
          next_st.bytes = st.bytes + 1'b1;
          if (st.bytes == BW'(IMAGE_BYTES - 1))
          begin
            next_st.init_cyc = '0;
            next_st.state = cms_pkg::CMS_ST_INIT;
          end
        end
      end
      cms_pkg::CMS_ST_INIT:
      begin
        next_st.init_cyc = st.init_cyc + 1'b1;
        if (st.init_cyc == IW'(INIT_CYC - 1))
        begin
          next_st.state = cms_pkg::CMS_ST_USER;
        end
      end
      cms_pkg::CMS_ST_USER:
      begin
      end
      default:
      begin
        next_st.state = cms_pkg::CMS_ST_RESET;
      end
    endcase
    if (restart)
    begin
      next_st.state = cms_pkg::CMS_ST_RESET;
      next_st.timeout = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      st <= '{state: cms_pkg::CMS_ST_RESET, req_prev: 1'b1, wr_prev: 1'b1, default: '0};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign user_mode = (st.state == cms_pkg::CMS_ST_USER);
  assign command_mode = !user_mode;
  assign config_done = user_mode || (st.state == cms_pkg::CMS_ST_INIT);
  assign chain_enable_out_n = !config_done;
  assign io_oe_allow = user_mode ? '1 : '0;
  assign io_weak_pullup = !config_done;
  assign init_reset_n = user_mode;
  assign load_timeout = st.timeout;
  assign pll_counters = st.pll_active;

  // Cycles spent initialising, for the length check
  logic [IW-1:0] init_watch;

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      init_watch <= '0;
    end
    else if (st.state == cms_pkg::CMS_ST_INIT)
    begin
      init_watch <= init_watch + 1'b1;
    end
    else
    begin
      init_watch <= '0;
    end
  end

  property p_io_hiz;
    @(posedge clk) disable iff (!rst_sync_n) !user_mode |-> (io_oe_allow == '0);
  endproperty
  a_io_hiz: assert property (p_io_hiz) else $error("I/O enabled outside user mode");

  property p_pullup;
    @(posedge clk) disable iff (!rst_sync_n) (st.state == cms_pkg::CMS_ST_LOAD) |-> io_weak_pullup;
  endproperty
  a_pullup: assert property (p_pullup) else $error("Pull-up missing during load");

  property p_init_len;
    @(posedge clk) disable iff (!rst_sync_n) $rose(user_mode) |-> (init_watch == IW'(INIT_CYC));
  endproperty
  a_init_len: assert property (p_init_len) else $error("Init phase length wrong");

  property p_modes;
    @(posedge clk) disable iff (!rst_sync_n)
      (command_mode != user_mode) && (!$rose(user_mode) || $past(st.state == cms_pkg::CMS_ST_INIT));
  endproperty
  a_modes: assert property (p_modes) else $error("Mode flags overlap");

  property p_restart;
    @(posedge clk) disable iff (!rst_sync_n) restart |=> (st.state == cms_pkg::CMS_ST_RESET) ##1 command_mode;
  endproperty
  a_restart: assert property (p_restart) else $error("Restart not taken");

  property p_chain_out;
    @(posedge clk) disable iff (!rst_sync_n) $rose(st.state == cms_pkg::CMS_ST_INIT) |-> !chain_enable_out_n;
  endproperty
  a_chain_out: assert property (p_chain_out) else $error("Chain enable not passed on");

  property p_chain_in;
    @(posedge clk) disable iff (!rst_sync_n) chain_enable_in_n |-> !in_word.valid;
  endproperty
  a_chain_in: assert property (p_chain_in) else $error("Data taken while chain disabled");

  property p_pll;
    @(posedge clk) disable iff (!rst_sync_n) pll_update |=> (pll_counters == $past(st.pll_shift));
  endproperty
  a_pll: assert property (p_pll) else $error("PLL counters not updated");

  property p_pll_keep;
    @(posedge clk) disable iff (!rst_sync_n) (user_mode && pll_update && !restart) |=> user_mode;
  endproperty
  a_pll_keep: assert property (p_pll_keep) else $error("PLL update disturbed mode");

  property p_first_load;
    @(posedge clk) disable iff (!rst_sync_n) (st.state == cms_pkg::CMS_ST_RESET && !restart) |=>
      (st.state == cms_pkg::CMS_ST_LOAD);
  endproperty
  a_first_load: assert property (p_first_load) else $error("Load not entered");

  property p_timeout_set;
    @(posedge clk) disable iff (!rst_sync_n)
      (st.state == cms_pkg::CMS_ST_LOAD && st.load_cyc == LW'(LOAD_LIMIT) && !restart) |=> load_timeout;
  endproperty
  a_timeout_set: assert property (p_timeout_set) else $error("Load timeout not flagged");

  property p_timeout_clear;
    @(posedge clk) disable iff (!rst_sync_n) restart |=> !load_timeout;
  endproperty
  a_timeout_clear: assert property (p_timeout_clear) else $error("Timeout kept over restart");

  property p_pll_hold;
    @(posedge clk) disable iff (!rst_sync_n) !pll_update |=> $stable(pll_counters);
  endproperty
  a_pll_hold: assert property (p_pll_hold) else $error("PLL counters moved without update");

  property p_pll_shift;
    @(posedge clk) disable iff (!rst_sync_n) (pll_from_pins ? pll_shift_pin : pll_shift_logic) |=>
      (st.pll_shift[0] == $past(pll_from_pins ? pll_data_pin : pll_data_logic));
  endproperty
  a_pll_shift: assert property (p_pll_shift) else $error("PLL chain bit lost");

  property p_async_take;
    @(posedge clk) disable iff (!rst_sync_n) (st.state == cms_pkg::CMS_ST_LOAD && !chain_enable_in_n &&
      scheme == cms_pkg::CMS_SRC_PASSIVE_PARALLEL_ASYNC && st.wr_prev && !par_write_n && fifo_in_ready) |=>
      fifo_out_valid;
  endproperty
  a_async_take: assert property (p_async_take) else $error("Host write not captured");

  property p_serial_bit;
    @(posedge clk) disable iff (!rst_sync_n) (st.state == cms_pkg::CMS_ST_LOAD && serial_scheme && serial_valid &&
      !chain_enable_in_n && fifo_in_ready) |=> (st.bit_cnt == $past(st.bit_cnt) + 3'h1);
  endproperty
  a_serial_bit: assert property (p_serial_bit) else $error("Serial bit not counted");
endmodule : cms_sequencer
`default_nettype wire

// ### testbench/cms_host_model.sv
/*
  Host or memory model that feeds configuration bytes in the chosen scheme.
  Assumes the bench pulses start for one cycle and then waits for busy to fall.
*/
`default_nettype none
module cms_host_model (
  // Control from bench
  input wire logic clk,
  input wire logic start,
  input wire logic [2:0] scheme,
  input wire logic [7:0] n_bytes,
  output logic busy,
  // Data toward the sequencer
  input wire logic data_ready,
  output logic serial_valid,
  output logic serial_data,
  output logic par_valid,
  output logic par_write_n,
  output logic [7:0] par_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] b;

  // Hold each unit until an edge sees ready
  task automatic wait_ready();
    @(posedge clk);
    while (!data_ready) @(posedge clk);
  endtask : wait_ready

  initial
  begin
    {busy, serial_valid, serial_data, par_valid, par_data, b} = '0;
    par_write_n = 1'b1;
    forever
    begin
      @(posedge clk);
      if (start)
      begin
        busy <= 1'b1;
        for (int i = 0; i < n_bytes; i++)
        begin
          b = 8'hA5 ^ 8'(i);
          if (scheme == 3'h3)
          begin
            par_valid <= 1'b1;
            par_data <= b;
            wait_ready();
          end
          else if (scheme == 3'h2)
          begin
            par_data <= b;
            par_write_n <= 1'b0;
            wait_ready();
            par_write_n <= 1'b1;
            @(posedge clk);
          end
          else
            for (int j = 7; j >= 0; j--)
            begin
              serial_valid <= 1'b1;
              serial_data <= b[j];
              wait_ready();
            end
        end
        // Released lines show the inverse of the last value
        par_valid <= 1'b0;
        serial_valid <= 1'b0;
        par_data <= ~b;
        serial_data <= ~b[0];
        busy <= 1'b0;
      end
    end
  end
endmodule : cms_host_model
`default_nettype wire

// ### testbench/tb.sv
/*
  Self-checking bench for the configuration and mode sequencer.
  Assumes a 10 MHz clock and the host model on the serial and parallel data inputs.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned NB = 4;
  localparam int unsigned NI = 4;
  logic clk, rst_n, cei_n, ceo_n, req_n, scan_p, sv, sd, pv, pw_n, rdy;
  logic cmd, usr, done, tmo, irst_n, pu, start, busy, pfp, psl, pdl, psp, pdp, pup;
  logic [7:0] pd, io;
  logic [23:0] pll;
  logic [2:0] sch;
  int fails, n_tests, cyc;

  cms_sequencer #(.IMAGE_BYTES(NB), .INIT_CYC(NI), .LOAD_LIMIT(200)) u_cms_sequencer (
    .clk(clk), .rst_n(rst_n), .scheme(cms_pkg::cms_scheme_e'(sch)), .chain_enable_in_n(cei_n),
    .chain_enable_out_n(ceo_n), .reconfig_request_n(req_n), .scan_pulse_reconfig(scan_p),
    .serial_valid(sv), .serial_data(sd), .par_valid(pv), .par_write_n(pw_n), .par_data(pd),
    .data_ready(rdy), .command_mode(cmd), .user_mode(usr), .config_done(done), .load_timeout(tmo),
    .init_reset_n(irst_n), .io_oe_allow(io), .io_weak_pullup(pu), .pll_from_pins(pfp),
    .pll_shift_logic(psl), .pll_data_logic(pdl), .pll_shift_pin(psp), .pll_data_pin(pdp),
    .pll_update(pup), .pll_counters(pll));

  cms_host_model u_cms_host_model (
    .clk(clk), .start(start), .scheme(sch), .n_bytes(8'(NB)), .busy(busy), .data_ready(rdy),
    .serial_valid(sv), .serial_data(sd), .par_valid(pv), .par_write_n(pw_n), .par_data(pd));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("comparisons=%0d mismatches=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic restart(input logic via_scan);
    @(posedge clk);
    if (via_scan)
      scan_p <= 1'b1;
    else
      req_n <= 1'b0;
    @(posedge clk);
    scan_p <= 1'b0;
    req_n <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check({cmd, usr, done}, 3'h4);
    check(io, 8'h00);
    check(pu, 1'b1);
    check(ceo_n, 1'b1);
  endtask : restart

  task automatic feed();
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(negedge clk);
    while (busy !== 1'b0) @(negedge clk);
  endtask : feed

  task automatic expect_user();
    int n;
    while (done !== 1'b1) @(negedge clk);
    check(ceo_n, 1'b0);
    check(cmd, 1'b1);
    check(io, 8'h00);
    check(irst_n, 1'b0);
    n = 0;
    while (usr !== 1'b1)
    begin
      n++;
      @(negedge clk);
    end
    check(n, NI);
    check(io, 8'hFF);
    check({cmd, pu, irst_n}, 3'h1);
    check(tmo, 1'b0);
  endtask : expect_user

  task automatic t_load(input logic [2:0] s, input logic via_scan);
    @(posedge clk);
    sch <= s;
    restart(via_scan);
    feed();
    expect_user();
  endtask : t_load

  task automatic t_chain_off();
    @(posedge clk);
    cei_n <= 1'b1;
    restart(1'b0);
    feed();
    repeat (250) @(negedge clk);
    check(done, 1'b0);
    check(tmo, 1'b1);
    @(posedge clk);
    cei_n <= 1'b0;
  endtask : t_chain_off

  // Both sources shift at once; only the selected one may land
  task automatic t_pll(input logic pins, input logic [23:0] v);
    logic [23:0] prev;
    prev = pll;
    @(posedge clk);
    pfp <= pins;
    for (int i = 23; i >= 0; i--)
    begin
      @(posedge clk);
      {psl, pdl, psp, pdp} <= pins ? {1'b1, ~v[i], 1'b1, v[i]} : {1'b1, v[i], 1'b1, ~v[i]};
    end
    @(posedge clk);
    {psl, psp} <= 2'b00;
    pup <= 1'b1;
    @(negedge clk);
    check(pll, prev);
    @(posedge clk);
    pup <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    check(pll, v);
    check({usr, io}, 9'h1FF);
  endtask : t_pll

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      fails++;
      report_and_stop();
    end
  end

  initial
  begin
    {rst_n, cei_n, scan_p, start, pfp, psl, pdl, psp, pdp, pup} = '0;
    req_n = 1'b1;
    sch = 3'h3;
    {fails, n_tests, cyc} = '0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check({cmd, usr}, 2'h2);
    check({io, pu, ceo_n, rdy}, 11'h007);
    check(pll, 24'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    feed();
    expect_user();
    t_pll(1'b0, 24'hC3A51E);
    t_pll(1'b1, 24'h5A0F96);
    for (int s = 0; s < 5; s++)
      t_load(3'(s), s[0]);
    t_chain_off();
    t_load(3'h2, 1'b0);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
